// [inc/lhg_pkg.sv]
// shared constants and types for the host / video graphics memory write path
`default_nettype none
package lhg_pkg;
  // panel and memory geometry
  localparam int H_PIX    = 176;
  localparam int V_LINES  = 240;
  localparam int PIX_W    = 18;
  localparam int SRC_BITS = 528;
  localparam int MEM_AW   = 16;
  localparam logic [7:0] LAST_PIX  = 8'hAF;
  localparam logic [7:0] LAST_LINE = 8'hEF;
  localparam logic [7:0] HALF_LINE = 8'h78;
  // instruction indexes
  localparam logic [6:0] IDX_OSC   = 7'h00;
  localparam logic [6:0] IDX_DRV   = 7'h01;
  localparam logic [6:0] IDX_ENTRY = 7'h03;
  localparam logic [6:0] IDX_CMP   = 7'h04;
  localparam logic [6:0] IDX_IFSEL = 7'h0C;
  localparam logic [6:0] IDX_STBY  = 7'h10;
  localparam logic [6:0] IDX_ADDR  = 7'h21;
  localparam logic [6:0] IDX_GRAPHICS_MEMORY  = 7'h22;
  localparam logic [6:0] IDX_MASK  = 7'h23;
  localparam logic [6:0] IDX_HWIN  = 7'h44;
  localparam logic [6:0] IDX_VWIN  = 7'h45;
  // field positions
  localparam int DRV_VSPL = 14, DRV_HSPL = 13, DRV_DPL = 12, DRV_EPL = 11;
  localparam int DRV_SM = 10, DRV_GS = 9, DRV_SS = 8;
  localparam int ENTRY_ID = 4;
  // reset values, interface select codes and status / serial padding
  localparam logic [15:0] HWIN_RST  = 16'hAF00;
  localparam logic [15:0] VWIN_RST  = 16'hEF00;
  localparam logic [15:0] ENTRY_RST = 16'h0010;
  localparam logic [1:0]  IFSEL_RGB = 2'h1;
  localparam logic [1:0]  IFSEL_VS  = 2'h2;
  localparam logic [7:0]  STAT_LOW  = 8'h00;
  localparam logic [1:0]  STAT_PAD  = 2'h0;
  localparam logic [5:0]  SPI_PAD   = 6'h00;
  // serial frame: 8-bit start byte (rw, rs in two last bits), 24-bit words
  localparam logic [4:0] SPI_START_LAST = 5'h07;
  localparam logic [4:0] SPI_WORD_LAST  = 5'h17;
  // internal line period
  localparam int CLK_NS   = 5;
  localparam int LINE_NS  = 2000;
  localparam int LINE_CYC = LINE_NS / CLK_NS;
  // synchronised pin vector positions
  localparam int P_VLD = 18, P_RS = 19, P_RD = 20, P_WR = 21, P_CS = 22;
  localparam int P_SDI = 23, P_SCK = 24, P_SCS = 25, P_IM = 26, P_PD = 27;
  localparam int P_EN = 45, P_DC = 46, P_HS = 47, P_VS = 48, P_EXT = 49, NPIN = 50;
  typedef enum logic [1:0] {SRC_SYS, SRC_RGB, SRC_VSYNC} lhg_src_t;
  typedef enum logic [1:0] {OP_REP, OP_OR, OP_AND, OP_XOR} lhg_op_t;
  typedef enum logic {SP_START, SP_DATA} lhg_spi_t;
endpackage
`default_nettype wire

// [inc/lhg_mem_if.sv]
// graphics memory access bundle: one bit-masked write port, two read ports
`timescale 1ns/1ps
`default_nettype none
interface lhg_mem_if #(parameter int AW = 16, parameter int DW = 18);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] wr_bits;
  logic [AW-1:0] ra_addr;
  logic [DW-1:0] ra_data;
  logic [AW-1:0] rb_addr;
  logic [DW-1:0] rb_data;
  modport ctrl (output wr_en, wr_addr, wr_data, wr_bits, ra_addr, rb_addr,
                input ra_data, rb_data);
  modport mem (input wr_en, wr_addr, wr_data, wr_bits, ra_addr, rb_addr,
               output ra_data, rb_data);
endinterface
`default_nettype wire

// [verilog/lhg_graphics_memory.sv]
// graphics memory array with per-bit write enables and two read ports
`timescale 1ns/1ps
`default_nettype none
module lhg_graphics_memory import lhg_pkg::*; #(
  parameter int DEPTH = H_PIX * V_LINES
) (
  // clock
  input wire logic ref_clk,
  // memory access
  lhg_mem_if.mem   m
);
  logic [PIX_W-1:0] mem_q [DEPTH];

  // per-bit write so masked bits keep their old value without a read cycle
  always_ff @(posedge ref_clk) begin
    if (m.wr_en && (int'(m.wr_addr) < DEPTH)) begin
      for (int b = 0; b < PIX_W; b++) begin
        if (m.wr_bits[b]) begin
          mem_q[m.wr_addr][b] <= m.wr_data[b];
        end
      end
    end
  end

  // separate refresh and host read ports, so neither waits on the other
  always_ff @(posedge ref_clk) begin
    m.ra_data <= mem_q[m.ra_addr];
    m.rb_data <= mem_q[m.rb_addr];
  end
endmodule
`default_nettype wire

// [verilog/lhg_top.sv]
// host and video write path into graphics memory, with refresh and line latch
`timescale 1ns/1ps
`default_nettype none
module lhg_top import lhg_pkg::*; #(
  parameter int LINE_CYC_P = LINE_CYC
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // parallel host port
  input  wire logic                host_cs_n,
  input  wire logic                host_wr_n,
  input  wire logic                host_rd_n,
  input  wire logic                register_select,
  input  wire logic                write_valid_qualifier,
  input  wire logic [PIX_W-1:0]    host_db_in,
  output logic      [PIX_W-1:0]    host_db_out,
  output logic                     host_db_oe,
  // serial host port
  input  wire logic                im_serial,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_sck,
  input  wire logic                spi_sdi,
  output logic                     spi_sdo,
  // rgb video port
  input  wire logic                vsync,
  input  wire logic                hsync,
  input  wire logic                dotclk,
  input  wire logic                enable,
  input  wire logic [PIX_W-1:0]    pixel_data_bus,
  // clock source
  input  wire logic                ext_clk_sel,
  output logic                     rc_osc_en,
  // panel drive
  output logic      [SRC_BITS-1:0] src_out,
  output logic      [7:0]          gate_line,
  output logic                     line_latch
);
  lhg_mem_if #(.AW(MEM_AW), .DW(PIX_W)) mem_if ();

  lhg_graphics_memory u_graphics_memory (
    .ref_clk (ref_clk),
    .m       (mem_if.mem)
  );

  // three-stage pin synchroniser; a change counts once stages two and three agree
  logic [NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, prev_q;
  assign pin_raw = {ext_clk_sel, vsync, hsync, dotclk, enable, pixel_data_bus, im_serial,
                    spi_cs_n, spi_sck, spi_sdi, host_cs_n, host_wr_n, host_rd_n,
                    register_select, write_valid_qualifier, host_db_in};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= '1;
      s2_q   <= '1;
      s3_q   <= '1;
      pin_q  <= '1;
      prev_q <= '1;
    end else begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      pin_q  <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
      prev_q <= pin_q;
    end
  end
  wire [NPIN-1:0] rise = pin_q & ~prev_q;
  wire [NPIN-1:0] fall = ~pin_q & prev_q;
  wire            im   = pin_q[P_IM];
  wire            vld  = pin_q[P_VLD];

  // control state
  logic [15:0]      index_q, drv_q, entry_q, hwin_q, vwin_q;
  logic [PIX_W-1:0] data_reg_q, cmp_q, mask_q, rd_hold_q;
  logic [7:0]       ac_x_q, ac_y_q, line_q;
  logic             stby_q, rd_load_q;
  lhg_src_t         src_q;

  // serial host: start byte then 24-bit words
  lhg_spi_t    sp_st_q;
  logic [4:0]  sp_cnt_q, sp_lim;
  logic [23:0] sp_sr_q, sp_out_q;
  logic        sp_rw_q, sp_rs_q;
  always_comb begin
    unique case (sp_st_q)
      SP_START: sp_lim = SPI_START_LAST;
      SP_DATA:  sp_lim = SPI_WORD_LAST;
    endcase
  end
  wire sck_r     = rise[P_SCK] & ~pin_q[P_SCS] & im;
  wire sp_last   = sck_r & (sp_cnt_q == sp_lim);
  wire start_end = sp_last & (sp_st_q == SP_START);
  wire word_end  = sp_last & (sp_st_q == SP_DATA);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sp_st_q  <= SP_START;
      sp_cnt_q <= '0;
      sp_sr_q  <= '0;
      sp_rw_q  <= 1'b0;
      sp_rs_q  <= 1'b0;
    end else if (pin_q[P_SCS]) begin
      sp_st_q  <= SP_START;
      sp_cnt_q <= '0;
    end else if (sck_r) begin
      sp_sr_q  <= {sp_sr_q[22:0], pin_q[P_SDI]};
      sp_cnt_q <= sp_last ? '0 : 5'(sp_cnt_q + 5'h01);
      if (start_end) begin
        sp_st_q <= SP_DATA;
        sp_rw_q <= sp_sr_q[0];
        sp_rs_q <= pin_q[P_SDI];
      end
    end
  end

  // host events from either port, each acting in the cycle it is seen
  wire p_wr = rise[P_WR] & ~pin_q[P_CS] & ~im;
  wire p_rd = fall[P_RD] & ~pin_q[P_CS] & ~im;
  wire s_wr = word_end & ~sp_rw_q;
  wire s_rd = (start_end & sp_sr_q[0]) | (word_end & sp_rw_q);
  wire host_wr = p_wr | s_wr;
  wire host_rd = p_rd | s_rd;
  wire host_rs = im ? (start_end ? pin_q[P_SDI] : sp_rs_q) : pin_q[P_RS];
  wire [PIX_W-1:0] host_dat = im ? {sp_sr_q[16:0], pin_q[P_SDI]} : pin_q[PIX_W-1:0];
  wire [6:0] idx     = index_q[6:0];
  wire       ctl_wr  = host_wr & host_rs;
  wire       is_graphics_memory = (idx == IDX_GRAPHICS_MEMORY);

  // instruction registers, all updated in the strobe cycle itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      index_q    <= '0;
      data_reg_q <= '0;
      drv_q      <= '0;
      entry_q    <= ENTRY_RST;
      cmp_q      <= '0;
      mask_q     <= '0;
      hwin_q     <= HWIN_RST;
      vwin_q     <= VWIN_RST;
    end else begin
      if (host_wr && !host_rs) index_q <= host_dat[15:0];
      if (ctl_wr) data_reg_q <= host_dat;
      if (ctl_wr && idx == IDX_DRV) drv_q <= host_dat[15:0];
      if (ctl_wr && idx == IDX_ENTRY) entry_q <= host_dat[15:0];
      if (ctl_wr && idx == IDX_CMP) cmp_q <= host_dat;
      if (ctl_wr && idx == IDX_MASK) mask_q <= host_dat;
      if (ctl_wr && idx == IDX_HWIN) hwin_q <= host_dat[15:0];
      if (ctl_wr && idx == IDX_VWIN) vwin_q <= host_dat[15:0];
    end
  end

  // interface select and standby; switching is by instruction only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_q  <= SRC_SYS;
      stby_q <= 1'b0;
    end else begin
      if (ctl_wr && idx == IDX_IFSEL) begin
        src_q <= (host_dat[1:0] == IFSEL_RGB) ? SRC_RGB :
                 (host_dat[1:0] == IFSEL_VS) ? SRC_VSYNC : SRC_SYS;
      end
      if (ctl_wr && idx == IDX_STBY) stby_q <= host_dat[0];
      else if (ctl_wr && idx == IDX_OSC && host_dat[0]) stby_q <= 1'b0;
    end
  end
  assign rc_osc_en = ~stby_q & ~pin_q[P_EXT];

  // video port and frame sync qualifiers, polarity from the driver register
  wire src_rgb   = (src_q == SRC_RGB);
  wire src_vs    = (src_q == SRC_VSYNC);
  wire dot_edge  = drv_q[DRV_DPL] ? fall[P_DC] : rise[P_DC];
  wire en_act    = (pin_q[P_EN] == drv_q[DRV_EPL]);
  wire rgb_step  = src_rgb & dot_edge & en_act;
  wire vs_edge   = drv_q[DRV_VSPL] ? rise[P_VS] : fall[P_VS];
  wire hs_edge   = drv_q[DRV_HSPL] ? rise[P_HS] : fall[P_HS];
  wire frame_rst = (src_rgb | src_vs) & vs_edge;

  // address counter stepping inside the window
  wire [7:0] hsa = hwin_q[7:0];
  wire [7:0] hea = hwin_q[15:8];
  wire [7:0] vsa = vwin_q[7:0];
  wire [7:0] vea = vwin_q[15:8];
  wire       inc      = entry_q[ENTRY_ID];
  wire       addr_set = ctl_wr & (idx == IDX_ADDR);
  wire       graphics_memory_stp = ctl_wr & is_graphics_memory & ~src_rgb;
  wire       ac_step  = graphics_memory_stp | rgb_step;
  wire       x_edge   = inc ? (ac_x_q == hea) : (ac_x_q == hsa);
  wire       y_edge   = inc ? (ac_y_q == vea) : (ac_y_q == vsa);
  wire [7:0] x_step   = inc ? 8'(ac_x_q + 8'h01) : 8'(ac_x_q - 8'h01);
  wire [7:0] y_step   = inc ? 8'(ac_y_q + 8'h01) : 8'(ac_y_q - 8'h01);
  wire [7:0] nx_x     = x_edge ? (inc ? hsa : hea) : x_step;
  wire [7:0] nx_y     = !x_edge ? ac_y_q : (y_edge ? (inc ? vsa : vea) : y_step);
  wire       in_win   = (ac_x_q >= hsa) && (ac_x_q <= hea) &&
                        (ac_y_q >= vsa) && (ac_y_q <= vea);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ac_x_q <= '0;
      ac_y_q <= '0;
    end else if (frame_rst) begin
      ac_x_q <= inc ? hsa : hea;
      ac_y_q <= inc ? vsa : vea;
    end else if (addr_set) begin
      ac_x_q <= host_dat[7:0];
      ac_y_q <= host_dat[15:8];
    end else if (ac_step) begin
      ac_x_q <= nx_x;
      ac_y_q <= nx_y;
    end
  end

  // write data: logic op with compare register, then per-bit mask
  wire [PIX_W-1:0] src_dat = rgb_step ? pin_q[P_PD +: PIX_W] : host_dat;
  wire lhg_op_t    op      = lhg_op_t'(entry_q[1:0]);
  wire [PIX_W-1:0] op_dat  = (op == OP_OR)  ? (src_dat | cmp_q) :
                             (op == OP_AND) ? (src_dat & cmp_q) :
                             (op == OP_XOR) ? (src_dat ^ cmp_q) : src_dat;
  wire graphics_memory_we = ac_step & ~vld & in_win & ~frame_rst & ~addr_set;
  assign mem_if.wr_en   = graphics_memory_we;
  assign mem_if.wr_addr = MEM_AW'(ac_y_q * H_PIX + ac_x_q);
  assign mem_if.wr_data = op_dat;
  assign mem_if.wr_bits = ~mask_q;
  assign mem_if.rb_addr = MEM_AW'(ac_y_q * H_PIX + ac_x_q);

  // host memory reads: answer from holding register, then refill it; counter untouched
  wire [PIX_W-1:0] rd_ans = host_rs ? rd_hold_q : {STAT_PAD, line_q, STAT_LOW};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_hold_q   <= '0;
      rd_load_q   <= 1'b0;
      host_db_out <= '0;
      sp_out_q    <= '0;
    end else begin
      rd_load_q <= host_rd & host_rs;
      if (rd_load_q) rd_hold_q <= mem_if.rb_data;
      if (host_rd) host_db_out <= rd_ans;
      if (host_rd && im) sp_out_q <= {SPI_PAD, rd_ans};
      else if (sck_r) sp_out_q <= {sp_out_q[22:0], 1'b0};
    end
  end
  assign host_db_oe = ~pin_q[P_CS] & ~pin_q[P_RD] & ~im;
  assign spi_sdo    = sp_out_q[23];

  // line timing: video port hsync, else internal divider halted in standby
  logic [15:0] div_q;
  wire div_end   = (div_q == 16'(LINE_CYC_P - 1));
  wire line_tick = src_rgb ? hs_edge : (div_end & ~stby_q);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q  <= '0;
      line_q <= '0;
    end else begin
      if (stby_q || div_end || frame_rst) div_q <= '0;
      else div_q <= 16'(div_q + 16'h0001);
      if (frame_rst) line_q <= '0;
      else if (line_tick) line_q <= (line_q == LAST_LINE) ? '0 : 8'(line_q + 8'h01);
    end
  end

  // gate row from scan order and direction
  wire [7:0] line_hi = 8'(line_q - HALF_LINE);
  wire [7:0] sm_row  = !drv_q[DRV_SM] ? line_q :
                       (line_q < HALF_LINE) ? {line_q[6:0], 1'b0} : {line_hi[6:0], 1'b1};
  wire [7:0] row     = drv_q[DRV_GS] ? 8'(LAST_LINE - sm_row) : sm_row;

  // refresh reader on its own memory port, one pixel per cycle
  logic [7:0]          rf_x_q, rf_row_q;
  logic                rf_busy_q, rf_v_q, rf_last_q;
  logic [SRC_BITS-1:0] line_sr_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rf_busy_q <= 1'b0;
      rf_x_q    <= '0;
      rf_row_q  <= '0;
      rf_v_q    <= 1'b0;
      rf_last_q <= 1'b0;
    end else begin
      if (line_tick) begin
        rf_busy_q <= 1'b1;
        rf_x_q    <= '0;
        rf_row_q  <= row;
      end else if (rf_busy_q) begin
        rf_busy_q <= (rf_x_q != LAST_PIX);
        rf_x_q    <= 8'(rf_x_q + 8'h01);
      end
      rf_v_q    <= rf_busy_q;
      rf_last_q <= rf_busy_q & (rf_x_q == LAST_PIX);
    end
  end
  assign mem_if.ra_addr = MEM_AW'(rf_row_q * H_PIX + rf_x_q);

  // collect one bit per colour; latch the line once all 528 are in
  logic [SRC_BITS-1:0] src_nx;
  for (genvar i = 0; i < SRC_BITS; i++) begin : g_ss
    assign src_nx[i] = drv_q[DRV_SS] ? line_sr_q[SRC_BITS-1-i] : line_sr_q[i];
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_sr_q  <= '0;
      line_latch <= 1'b0;
      src_out    <= '0;
      gate_line  <= '0;
    end else begin
      if (rf_v_q) begin
        line_sr_q <= {line_sr_q[SRC_BITS-4:0], mem_if.ra_data[17], mem_if.ra_data[11],
                      mem_if.ra_data[5]};
      end
      line_latch <= rf_v_q & rf_last_q;
      if (line_latch) begin
        src_out   <= src_nx;
        gate_line <= rf_row_q;
      end
    end
  end

  // checks kept beside the logic they guard
  wr_qual_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    graphics_memory_we |-> !vld && (src_rgb || (im ? !pin_q[P_SCS] : !pin_q[P_CS])))
    else $error("memory written without select and qualifier low");
  ac_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(ac_step || addr_set || frame_rst) |=> $stable(ac_x_q) && $stable(ac_y_q))
    else $error("address counter moved without cause");
  drv_novld_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctl_wr && idx == IDX_DRV |=> drv_q == $past(host_dat[15:0]))
    else $error("control write lost");
  idx_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    host_wr && !host_rs |=> index_q == $past(host_dat[15:0]))
    else $error("index not loaded");
  rgb_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !src_rgb |-> !rgb_step)
    else $error("video pixel taken outside video mode");
  step_inc_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ac_step && !addr_set && !frame_rst && inc && !x_edge
    |=> ac_x_q == 8'($past(ac_x_q) + 8'h01))
    else $error("counter did not step by one");
  win_wr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    mem_if.wr_en |-> in_win)
    else $error("write outside window");
  latch_line_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    line_tick ##1 (!line_tick)[*8] |-> rf_busy_q)
    else $error("refresh stopped before line complete");
  osc_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    stby_q |-> !rc_osc_en ##1 div_q == 16'h0000)
    else $error("oscillator runs in standby");
endmodule
`default_nettype wire

// [tb/lhg_host_model.sv]
// host processor and video source model for the write path bench
`timescale 1ns/1ps
`default_nettype none
module lhg_host_model import lhg_pkg::*; (
  // clock
  input  wire logic             ref_clk,
  // parallel host port
  output logic                  host_cs_n,
  output logic                  host_wr_n,
  output logic                  host_rd_n,
  output logic                  register_select,
  output logic                  write_valid_qualifier,
  output logic      [PIX_W-1:0] host_db_in,
  input  wire logic [PIX_W-1:0] host_db_out,
  // serial host port
  output logic                  im_serial,
  output logic                  spi_cs_n,
  output logic                  spi_sck,
  output logic                  spi_sdi,
  input  wire logic             spi_sdo,
  // video port
  output logic                  vsync,
  output logic                  hsync,
  output logic                  dotclk,
  output logic                  enable,
  output logic      [PIX_W-1:0] pixel_data_bus
);
  // idle levels; serial clock parks low outside frames
  initial begin
    {host_cs_n, host_wr_n, host_rd_n, spi_cs_n, vsync, hsync} = 6'h3F;
    {register_select, write_valid_qualifier, im_serial} = 3'h0;
    {spi_sck, spi_sdi, dotclk, enable} = 4'h0;
    host_db_in = 18'h0_0000;
    pixel_data_bus = 18'h0_0000;
  end
  // pins pass a three-flop synchroniser, so every level stands 8 cycles
  task automatic hold();
    repeat (8) @(negedge ref_clk);
  endtask
  // one parallel cycle; q is taken while the read strobe is still low
  task automatic par(input logic cs_n, rd, rs, vld, input logic [PIX_W-1:0] d,
                     output logic [PIX_W-1:0] q);
    @(negedge ref_clk);
    im_serial = 1'b0;
    {host_cs_n, register_select, write_valid_qualifier} = {cs_n, rs, vld};
    host_db_in = d;
    hold();
    if (rd) host_rd_n = 1'b0;
    else host_wr_n = 1'b0;
    hold();
    q = host_db_out;
    {host_wr_n, host_rd_n} = 2'h3;
    hold();
    host_cs_n = 1'b1;
    host_db_in = ~d;
  endtask
  // serial frame: start byte then nw whole words; q keeps the last 24 bits seen
  task automatic spi(input logic rw, rs, input int nw, input logic [23:0] w,
                     output logic [23:0] q);
    logic [7:0] sb;
    sb = {SPI_PAD, rw, rs};
    q = 24'h00_0000;
    im_serial = 1'b1;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 + 24 * nw; i++) begin
      spi_sdi = (i < 8) ? sb[7 - i] : w[23 - (i - 8) % 24];
      hold();
      q = {q[22:0], spi_sdo};
      spi_sck = 1'b1;
      hold();
      spi_sck = 1'b0;
    end
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    hold();
  endtask
  // one dot clock period, rising edge active at reset polarity
  task automatic dot(input logic en, vld, input logic [PIX_W-1:0] d);
    @(negedge ref_clk);
    {enable, write_valid_qualifier, pixel_data_bus} = {en, vld, d};
    hold();
    dotclk = 1'b1;
    hold();
    dotclk = 1'b0;
    pixel_data_bus = ~d;
  endtask
  // frame start: low-active vertical sync pulse
  task automatic frame();
    @(negedge ref_clk);
    vsync = 1'b0;
    hold();
    vsync = 1'b1;
    hold();
  endtask
endmodule
`default_nettype wire

// [tb/lhg_top_tb_top.sv]
// self-checking bench for the host and video graphics memory write path
`timescale 1ns/1ps
`default_nettype none
module lhg_top_tb_top import lhg_pkg::*; ;
  // pins between bench, host model and design
  logic                ref_clk, rstn, ext_clk_sel, host_db_oe, rc_osc_en, line_latch;
  logic                host_cs_n, host_wr_n, host_rd_n, register_select, write_valid_qualifier;
  logic                im_serial, spi_cs_n, spi_sck, spi_sdi, spi_sdo;
  logic                vsync, hsync, dotclk, enable;
  logic [PIX_W-1:0]    host_db_in, host_db_out, pixel_data_bus, q;
  logic [SRC_BITS-1:0] src_out;
  logic [7:0]          gate_line;
  logic [23:0]         sq;
  int                  failures, cmp_count, n, oe_cyc;
  // replace, or, and, xor of 0F0F against compare value 00FF
  logic [PIX_W-1:0]    op_exp [4] = '{18'h0_0F0F, 18'h0_0FFF, 18'h0_000F, 18'h0_0FF0};
  // serial frames: index, address, index, pixel, then address again for the read
  logic [23:0]         sf_w [7] = '{{17'h0_0000, IDX_ADDR}, 24'h00_0205,
    {17'h0_0000, IDX_GRAPHICS_MEMORY}, 24'h02_5A5A, {17'h0_0000, IDX_ADDR}, 24'h00_0205,
    {17'h0_0000, IDX_GRAPHICS_MEMORY}};
  // short line period so a refresh line is seen quickly
  lhg_top #(.LINE_CYC_P(200)) u_dut (
    .ref_clk, .rstn, .host_cs_n, .host_wr_n, .host_rd_n, .register_select,
    .write_valid_qualifier, .host_db_in, .host_db_out, .host_db_oe, .im_serial,
    .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo, .vsync, .hsync, .dotclk, .enable,
    .pixel_data_bus, .ext_clk_sel, .rc_osc_en, .src_out, .gate_line, .line_latch
  );
  // far side: host processor and video source
  lhg_host_model u_host (
    .ref_clk, .host_cs_n, .host_wr_n, .host_rd_n, .register_select,
    .write_valid_qualifier, .host_db_in, .host_db_out, .im_serial, .spi_cs_n,
    .spi_sck, .spi_sdi, .spi_sdo, .vsync, .hsync, .dotclk, .enable, .pixel_data_bus
  );
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // cycles in which the design drives the parallel data pins
  always @(negedge ref_clk) if (host_db_oe === 1'b1) oe_cyc++;
  // compare and count
  task automatic check(input string what, input logic [PIX_W-1:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // parallel accesses through the host model
  task automatic wr(input logic rs, input logic [PIX_W-1:0] d, input logic vld = 1'b0);
    u_host.par(1'b0, 1'b0, rs, vld, d, q);
  endtask
  task automatic rd(input logic rs);
    u_host.par(1'b0, 1'b1, rs, 1'b0, 18'h0_0000, q);
  endtask
  task automatic reg_wr(input logic [6:0] idx, input logic [PIX_W-1:0] v,
                        input logic vld = 1'b0);
    wr(1'b0, PIX_W'(idx), vld);
    wr(1'b1, v, vld);
  endtask
  // aim the counter at column x of line y, then select memory data
  task automatic set_at(input logic [7:0] x, y);
    reg_wr(IDX_ADDR, {2'h0, y, x});
    wr(1'b0, PIX_W'(IDX_GRAPHICS_MEMORY));
  endtask
  // stale first word is dropped; a third read proves the counter stood still
  task automatic peek(input logic [7:0] x, y, input logic [PIX_W-1:0] exp);
    set_at(x, y);
    rd(1'b1);
    rd(1'b1);
    check("memory word", exp, q);
    rd(1'b1);
    check("memory word again", exp, q);
  endtask
  // verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    {rstn, ext_clk_sel} = 2'h0;
    failures = 0;
    cmp_count = 0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (8) @(negedge ref_clk);
    set_at(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) wr(1'b1, PIX_W'(18'h1_0000 + i));
    reg_wr(IDX_ADDR, 18'h0_0000, 1'b1);
    wr(1'b0, PIX_W'(IDX_GRAPHICS_MEMORY), 1'b1);
    wr(1'b1, 18'h2_AAAA);
    u_host.par(1'b1, 1'b0, 1'b1, 1'b0, 18'h3_3333, q);
    wr(1'b1, 18'h2_BBBB, 1'b1);
    wr(1'b1, 18'h2_CCCC);
    peek(8'h00, 8'h00, 18'h2_AAAA);
    peek(8'h01, 8'h00, 18'h1_0001);
    peek(8'h02, 8'h00, 18'h2_CCCC);
    peek(8'h03, 8'h00, 18'h1_0003);
    oe_cyc = 0;
    rd(1'b0);
    check("status low byte", 18'h0_0000, q & 18'h3_00FF);
    check("read drive cycles", 18'h0_0008, PIX_W'(oe_cyc));
    $display("test host stepping done");
    reg_wr(IDX_MASK, 18'h0_00FF);
    set_at(8'h00, 8'h00);
    wr(1'b1, 18'h3_FFFF);
    reg_wr(IDX_MASK, 18'h0_0000);
    peek(8'h00, 8'h00, 18'h3_FFAA);
    reg_wr(IDX_CMP, 18'h0_00FF);
    for (int op = 0; op < 4; op++) begin
      reg_wr(IDX_ENTRY, PIX_W'(16'h0010 + op));
      set_at(8'h01, 8'h00);
      wr(1'b1, 18'h0_0F0F);
      peek(8'h01, 8'h00, op_exp[op]);
    end
    reg_wr(IDX_ENTRY, {2'h0, ENTRY_RST});
    $display("test mask and logic done");
    reg_wr(IDX_HWIN, 18'h0_0100);
    set_at(8'h00, 8'h00);
    for (int i = 0; i < 3; i++) wr(1'b1, PIX_W'(18'h0_5550 + i));
    set_at(8'h02, 8'h00);
    wr(1'b1, 18'h0_6666);
    reg_wr(IDX_HWIN, {2'h0, HWIN_RST});
    peek(8'h00, 8'h01, 18'h0_5552);
    peek(8'h02, 8'h00, 18'h2_CCCC);
    $display("test window done");
    for (int i = 0; i < 7; i++) u_host.spi(1'b0, i[0], 1, sf_w[i], sq);
    u_host.spi(1'b1, 1'b1, 2, 24'h00_0000, sq);
    check("serial memory read", 18'h2_5A5A, sq[PIX_W-1:0]);
    u_host.spi(1'b1, 1'b0, 1, 24'h00_0000, sq);
    check("serial status", 18'h0_0000, sq[PIX_W-1:0] & 18'h3_00FF);
    $display("test serial done");
    reg_wr(IDX_IFSEL, 18'h0_0001);
    u_host.frame();
    wr(1'b0, PIX_W'(IDX_GRAPHICS_MEMORY));
    wr(1'b1, 18'h1_1111);
    u_host.dot(1'b0, 1'b0, 18'h0_7770);
    u_host.dot(1'b1, 1'b0, 18'h0_7771);
    u_host.dot(1'b0, 1'b1, 18'h0_7772);
    u_host.dot(1'b0, 1'b0, 18'h0_7773);
    reg_wr(IDX_IFSEL, 18'h0_0000);
    peek(8'h00, 8'h00, 18'h0_7770);
    peek(8'h01, 8'h00, 18'h0_5551);
    peek(8'h02, 8'h00, 18'h0_7773);
    $display("test video port done");
    check("oscillator on", 18'h0_0001, PIX_W'(rc_osc_en));
    reg_wr(IDX_STBY, 18'h0_0001);
    check("oscillator standby", 18'h0_0000, PIX_W'(rc_osc_en));
    reg_wr(IDX_OSC, 18'h0_0001);
    check("oscillator restart", 18'h0_0001, PIX_W'(rc_osc_en));
    ext_clk_sel = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("external clock", 18'h0_0000, PIX_W'(rc_osc_en));
    ext_clk_sel = 1'b0;
    $display("test clock source done");
    // known pixel at the start of the last row, then frame-sync mode restarts line count
    set_at(8'h00, 8'hEF);
    wr(1'b1, 18'h2_0800);
    reg_wr(IDX_DRV, 18'h0_0300);
    reg_wr(IDX_IFSEL, 18'h0_0002);
    u_host.frame();
    // let any line begun before the frame start finish first
    repeat (200) @(negedge ref_clk);
    n = 0;
    while (line_latch !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    check("line latch pulse", 18'h0_0001, PIX_W'(line_latch));
    @(negedge ref_clk);
    check("gate row", 18'h0_00EF, PIX_W'(gate_line));
    check("source bits", 18'h0_0003, PIX_W'(src_out[2:0]));
    $display("test line latch done");
    close_out();
  end
endmodule
`default_nettype wire
